//--- rtl/pwr_mode_defines.vh
// Register map, field positions and timing counts for the power mode block
`ifndef PWR_MODE_DEFINES_VH
`define PWR_MODE_DEFINES_VH

// Register indices and byte addresses (byte address is index times four, one word each)
`define PM_IDX_PWR_CTRL     8'h87
`define PM_IDX_AUX_FUNC     8'ha2
`define PM_ADDR_PWR_CTRL    12'h21c
`define PM_ADDR_AUX_FUNC    12'h288
`define PM_ADDR_STATUS      12'h300
`define PM_ADDR_IRQ_STAT    12'h304
`define PM_ADDR_IRQ_MASK    12'h308
`define PM_ADDR_WAKE_CFG    12'h30c

// Power control fields
`define PC_LIGHT_SLEEP      0
`define PC_DEEP_SLEEP       1
`define PC_BROWNOUT_FLAG    5
`define PC_POWER_ON_FLAG    4

// Aux function fields
`define AUX_BROWNOUT_DIS    6
`define AUX_BROWNOUT_IRQ    5

// Reset values of power control per cause
`define PC_RST_POWER_ON     8'h30
`define PC_RST_BROWNOUT     8'h20
`define PC_RST_OTHER        8'h00

// Oscillator start-up counts
`define OSC_WAIT_CRYSTAL    11'd1024
`define OSC_WAIT_RC         11'd256

// AXI responses
`define AXI_RESP_OKAY       2'b00
`define AXI_RESP_SLVERR     2'b10

`endif

//--- rtl/power_mode_and_supply_monitor.v
// Power mode control, supply monitor flags and register slave
//
// Operation
// R01: Config bit 1 low threshold, 0 high
// R02: Disable bit stops brownout reset and interrupt
// R03: Power-on sets flag, held until software clears
// R04: Brownout or power-up sets brownout flag, sticky
// R05: Light sleep halts CPU, peripherals run
// R06: Light sleep ends on interrupt/reset, bit clears
// R07: Deep sleep stops oscillator, bit clears on exit
// R08: Deep sleep exits on reset or permitted wake
// R09: Wake holds CPU 1024 or 256 clocks
// R10: Brownout reset asserts at once, even asleep
// R11: Brownout interrupt wakes from deep sleep
// R12: Watchdog runs on own oscillator, resets anytime
// R13: Brownout, watchdog, comparators keep running asleep
// R14: Control resets 30, 20 or 00 by cause
// R15: Irq select picks brownout interrupt or reset
// R16: Both sleep bits set gives deep sleep
//
// Design decision made here: register access over AXI4-Lite.
`include "pwr_mode_defines.vh"
`default_nettype none

module power_mode_and_supply_monitor (
    input  wire        i_mclk,
    input  wire        i_reset,
    input  wire        i_por_detect,
    input  wire        i_brownout_low_raw,
    input  wire        i_brownout_high_raw,
    input  wire        i_wdt_reset_async,
    input  wire        i_brownout_level_select,
    input  wire        i_crystal_osc_cfg,
    input  wire        i_irq_pending,
    input  wire        i_wake_irq,
    input  wire        i_brownout_irq_enable,
    input  wire [11:0] i_awaddr,
    input  wire        i_awvalid,
    output reg         o_awready,
    input  wire [31:0] i_wdata,
    input  wire [3:0]  i_wstrb,
    input  wire        i_wvalid,
    output reg         o_wready,
    output reg  [1:0]  o_bresp,
    output reg         o_bvalid,
    input  wire        i_bready,
    input  wire [11:0] i_araddr,
    input  wire        i_arvalid,
    output reg         o_arready,
    output reg  [31:0] o_rdata,
    output reg  [1:0]  o_rresp,
    output reg         o_rvalid,
    input  wire        i_rready,
    output reg         o_cpu_halt,
    output reg         o_osc_stop,
    output reg         o_sys_reset,
    output reg         o_brownout_irq,
    output reg         o_uart_rate_double,
    output reg         o_uart_bit7_select,
    output reg         o_irq
);

    // Mode states, one-hot
    localparam [3:0] ST_RUN   = 4'b0001;
    localparam [3:0] ST_LIGHT = 4'b0010;
    localparam [3:0] ST_DEEP  = 4'b0100;
    localparam [3:0] ST_WAKE  = 4'b1000;

    // Two-flop synchronisers for the analog and foreign-clock inputs
    reg [3:0] sync1_q;
    reg [3:0] sync2_q;
    always @(posedge i_mclk) begin
        sync1_q <= {i_wdt_reset_async, i_brownout_high_raw,
                    i_brownout_low_raw, i_por_detect};
        sync2_q <= sync1_q;
    end
    wire por_s     = sync2_q[0];
    wire bo_low_s  = sync2_q[1];
    wire bo_high_s = sync2_q[2];
    // Watchdog lives on its own oscillator, so it is honoured asleep too
    wire wdt_s     = sync2_q[3]; // R12 R13

    reg [7:0]  power_control_q;
    reg [7:0]  aux_function_reg_q;
    reg [1:0]  irq_stat_q;
    reg [1:0]  irq_mask_q;
    reg [3:0]  state_q;
    reg [10:0] wait_cnt_q;

    wire bo_dis  = aux_function_reg_q[`AUX_BROWNOUT_DIS];
    wire bo_isel = aux_function_reg_q[`AUX_BROWNOUT_IRQ];
    // Unprogrammed bit picks the lower trip point
    wire bo_below = i_brownout_level_select ? bo_low_s : bo_high_s; // R01
    // Detector is not clocked by the main oscillator
    wire bo_event = bo_below & ~bo_dis; // R02 R13
    wire bo_rst   = bo_event & ~bo_isel; // R10 R15
    wire bo_irq   = bo_event & bo_isel; // R15
    wire any_rst  = i_reset | por_s | bo_rst | wdt_s;

    // AXI write path
    reg [11:0] aw_q;
    reg        aw_have_q;
    reg [31:0] w_q;
    reg [3:0]  ws_q;
    reg        w_have_q;
    wire       do_write = aw_have_q & w_have_q & ~o_bvalid;
    wire       wr_pc    = do_write & (aw_q == `PM_ADDR_PWR_CTRL) & ws_q[0];
    wire       wr_aux   = do_write & (aw_q == `PM_ADDR_AUX_FUNC) & ws_q[0];
    wire       wr_ist   = do_write & (aw_q == `PM_ADDR_IRQ_STAT) & ws_q[0];
    wire       wr_imsk  = do_write & (aw_q == `PM_ADDR_IRQ_MASK) & ws_q[0];
    wire       wr_known = (aw_q == `PM_ADDR_PWR_CTRL) |
                          (aw_q == `PM_ADDR_AUX_FUNC) |
                          (aw_q == `PM_ADDR_STATUS) |
                          (aw_q == `PM_ADDR_IRQ_STAT) |
                          (aw_q == `PM_ADDR_IRQ_MASK) |
                          (aw_q == `PM_ADDR_WAKE_CFG);

    always @(posedge i_mclk) begin
        if (i_reset) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            aw_q      <= 12'h000;
            w_q       <= 32'h0000_0000;
            ws_q      <= 4'h0;
            o_awready <= 1'b0;
            o_wready  <= 1'b0;
            o_bvalid  <= 1'b0;
            o_bresp   <= `AXI_RESP_OKAY;
        end else begin
            o_awready <= 1'b0;
            o_wready  <= 1'b0;
            if (i_awvalid & ~aw_have_q & ~o_awready) begin
                aw_q      <= i_awaddr;
                aw_have_q <= 1'b1;
                o_awready <= 1'b1;
            end
            if (i_wvalid & ~w_have_q & ~o_wready) begin
                w_q      <= i_wdata;
                ws_q     <= i_wstrb;
                w_have_q <= 1'b1;
                o_wready <= 1'b1;
            end
            if (do_write) begin
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
                o_bvalid  <= 1'b1;
                o_bresp   <= wr_known ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
            end else if (o_bvalid & i_bready) begin
                o_bvalid <= 1'b0;
            end
        end
    end

    // AXI read path
    reg [31:0] rd_d;
    reg        rd_ok;
    always @* begin
        rd_d  = 32'h0000_0000;
        rd_ok = 1'b1;
        case (i_araddr)
            `PM_ADDR_PWR_CTRL: rd_d = {24'h000000, power_control_q};
            `PM_ADDR_AUX_FUNC: rd_d = {24'h000000, aux_function_reg_q};
            `PM_ADDR_STATUS:   rd_d = {28'h0000000, state_q};
            `PM_ADDR_IRQ_STAT: rd_d = {30'h0, irq_stat_q};
            `PM_ADDR_IRQ_MASK: rd_d = {30'h0, irq_mask_q};
            `PM_ADDR_WAKE_CFG: rd_d = {21'h000000, wait_cnt_q};
            default:           rd_ok = 1'b0;
        endcase
    end

    always @(posedge i_mclk) begin
        if (i_reset) begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b0;
            o_rdata   <= 32'h0000_0000;
            o_rresp   <= `AXI_RESP_OKAY;
        end else begin
            o_arready <= 1'b0;
            if (i_arvalid & ~o_rvalid & ~o_arready) begin
                o_arready <= 1'b1;
                o_rvalid  <= 1'b1;
                o_rdata   <= rd_d;
                o_rresp   <= rd_ok ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
            end else if (o_rvalid & i_rready) begin
                o_rvalid <= 1'b0;
            end
        end
    end

    // Wake qualified by the interrupt controller's enable/priority check
    wire light_exit = i_irq_pending; // R06
    wire deep_exit  = i_wake_irq | (bo_irq & i_brownout_irq_enable); // R08 R11
    // Crystal needs the longer settling count
    wire [10:0] osc_wait = i_crystal_osc_cfg ? `OSC_WAIT_CRYSTAL
                                             : `OSC_WAIT_RC; // R09

    // Sleep mode sequencer and power control register
    always @(posedge i_mclk) begin
        if (any_rst) begin
            // Power-on wins over brownout; the reset pin counts as power-on
            if (por_s | i_reset)
                power_control_q <= `PC_RST_POWER_ON; // R14 R03 R04
            else if (bo_rst)
                power_control_q <= `PC_RST_BROWNOUT; // R14 R04 R10
            else
                power_control_q <= `PC_RST_OTHER; // R14
            aux_function_reg_q <= 8'h02;
            state_q            <= ST_RUN;
            wait_cnt_q         <= 11'd0;
        end else begin
            if (wr_pc)
                power_control_q <= w_q[7:0];
            // Hardware sets win over a software clear in the same cycle
            if (bo_irq)
                power_control_q[`PC_BROWNOUT_FLAG] <= 1'b1; // R04
            if (wr_aux)
                aux_function_reg_q <= {w_q[7:5], aux_function_reg_q[4:0]};
            case (state_q)
                ST_RUN: begin
                    if (wr_pc & w_q[`PC_DEEP_SLEEP])
                        state_q <= ST_DEEP; // R16 R07
                    else if (wr_pc & w_q[`PC_LIGHT_SLEEP])
                        state_q <= ST_LIGHT; // R05
                end
                ST_LIGHT: begin
                    if (light_exit) begin
                        state_q <= ST_RUN;
                        power_control_q[`PC_LIGHT_SLEEP] <= 1'b0; // R06
                    end
                end
                ST_DEEP: begin
                    if (deep_exit) begin
                        state_q    <= ST_WAKE;
                        wait_cnt_q <= osc_wait; // R09
                    end
                end
                ST_WAKE: begin
                    if (wait_cnt_q <= 11'd1) begin
                        state_q <= ST_RUN;
                        power_control_q[`PC_DEEP_SLEEP]  <= 1'b0; // R07
                        power_control_q[`PC_LIGHT_SLEEP] <= 1'b0; // R16
                    end
                    wait_cnt_q <= wait_cnt_q - 11'd1;
                end
                default: state_q <= ST_RUN;
            endcase
        end
    end

    // Event status, write one to clear, set wins
    always @(posedge i_mclk) begin
        if (i_reset) begin
            irq_stat_q <= 2'b00;
            irq_mask_q <= 2'b00;
        end else begin
            irq_stat_q <= (irq_stat_q & ~(wr_ist ? w_q[1:0] : 2'b00)) |
                          {deep_exit & (state_q == ST_DEEP), bo_irq};
            if (wr_imsk)
                irq_mask_q <= w_q[1:0];
        end
    end

    // Registered outputs
    always @(posedge i_mclk) begin
        if (i_reset) begin
            o_cpu_halt         <= 1'b1;
            o_osc_stop         <= 1'b0;
            o_sys_reset        <= 1'b1;
            o_brownout_irq     <= 1'b0;
            o_uart_rate_double <= 1'b0;
            o_uart_bit7_select <= 1'b0;
            o_irq              <= 1'b0;
        end else begin
            o_cpu_halt  <= (state_q != ST_RUN) | any_rst; // R05 R09
            o_osc_stop  <= (state_q == ST_DEEP); // R07
            o_sys_reset <= any_rst; // R10 R12
            o_brownout_irq     <= bo_irq; // R02 R11
            o_uart_rate_double <= power_control_q[7];
            o_uart_bit7_select <= power_control_q[6];
            o_irq              <= |(irq_stat_q & irq_mask_q);
        end
    end

endmodule

`default_nettype wire

//--- dv/pwr_mode_monitor.sv
// Port-level assertions for the power mode block
`default_nettype none
module pwr_mode_monitor (
    input wire logic        i_mclk,
    input wire logic        i_reset,
    input wire logic        i_wdt_reset_async,
    input wire logic        i_wake_irq,
    input wire logic        i_brownout_irq_enable,
    input wire logic        i_bready,
    input wire logic        i_rready,
    input wire logic        o_bvalid,
    input wire logic        o_rvalid,
    input wire logic [31:0] o_rdata,
    input wire logic        o_cpu_halt,
    input wire logic        o_osc_stop,
    input wire logic        o_sys_reset,
    input wire logic        o_brownout_irq
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_reset);

    chk_wdt_reset: assert property (
        $rose(i_wdt_reset_async) |-> ##[1:5] o_sys_reset)
        else $error("watchdog reset not seen");
    chk_reset_halts: assert property (o_sys_reset |-> o_cpu_halt)
        else $error("cpu runs during reset");
    chk_deep_halts: assert property (o_osc_stop |-> o_cpu_halt)
        else $error("cpu runs with oscillator stopped");
    chk_wake_exits: assert property (
        o_osc_stop && i_wake_irq |-> ##[1:4] !o_osc_stop)
        else $error("wake source ignored in deep sleep");
    chk_bo_wakes: assert property (
        o_osc_stop && o_brownout_irq && i_brownout_irq_enable
        |-> ##[1:4] !o_osc_stop)
        else $error("brownout interrupt ignored in deep sleep");
    chk_wake_wait: assert property (
        $fell(o_osc_stop) && !o_sys_reset |-> o_cpu_halt [*8])
        else $error("cpu released before start-up count");
    chk_bvalid_hold: assert property (o_bvalid && !i_bready |=> o_bvalid)
        else $error("write response dropped early");
    chk_rdata_hold: assert property (
        o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
        else $error("read data not held");

    cover property (o_osc_stop ##1 !o_osc_stop);
    cover property (o_brownout_irq && o_osc_stop);
    cover property ($rose(o_sys_reset));
endmodule

bind power_mode_and_supply_monitor pwr_mode_monitor pwr_mode_monitor_i (.*);
`default_nettype wire

//--- dv/tb.sv
// Register-level testbench for the power mode block
`include "pwr_mode_defines.vh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        i_mclk = 0, i_reset = 1, i_por_detect = 0;
    logic        i_brownout_low_raw = 0, i_brownout_high_raw = 0;
    logic        i_wdt_reset_async = 0, i_crystal_osc_cfg = 0;
    logic        i_brownout_level_select = 1, i_irq_pending = 0;
    logic        i_wake_irq = 0, i_brownout_irq_enable = 0;
    logic        i_awvalid = 0, i_wvalid = 0, i_bready = 0;
    logic        i_arvalid = 0, i_rready = 0;
    logic [11:0] i_awaddr = 12'h000, i_araddr = 12'h000;
    logic [31:0] i_wdata = 32'h0, o_rdata, rd;
    logic [3:0]  i_wstrb = 4'hf;
    logic [1:0]  o_bresp, o_rresp, rsp;
    logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic        o_cpu_halt, o_osc_stop, o_sys_reset, o_brownout_irq;
    logic        o_uart_rate_double, o_uart_bit7_select, o_irq;
    int          fails = 0, n_tests = 0, n;

    always #2.5 i_mclk = ~i_mclk;

    power_mode_and_supply_monitor power_mode_and_supply_monitor_i (.*);

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Each request held until its own ready is seen at a rising edge
    task automatic xf(input bit wr, input logic [11:0] a,
                      input logic [31:0] d);
        bit done;
        done = 0;
        @(posedge i_mclk);
        i_awaddr <= a;
        i_araddr <= a;
        i_wdata <= d;
        i_awvalid <= wr;
        i_wvalid <= wr;
        i_bready <= wr;
        i_arvalid <= !wr;
        i_rready <= !wr;
        for (int k = 0; k < 100 && !done; k++) begin
            @(posedge i_mclk);
            if (i_awvalid && o_awready) i_awvalid <= 1'h0;
            if (i_wvalid && o_wready) i_wvalid <= 1'h0;
            if (i_arvalid && o_arready) i_arvalid <= 1'h0;
            done = wr ? (o_bvalid && i_bready) : (o_rvalid && i_rready);
            if (done) begin
                rsp = wr ? o_bresp : o_rresp;
                if (!wr) rd = o_rdata;
                i_bready <= 1'h0;
                i_rready <= 1'h0;
            end
        end
        if (!done) begin
            fails++;
            wrap_up();
        end
    endtask

    // Counts halted cycles until the cpu is released
    task automatic run;
        n = 0;
        @(posedge i_mclk);
        while (o_cpu_halt !== 1'h0) begin
            n++;
            if (n > 3000) begin
                fails++;
                wrap_up();
            end
            @(posedge i_mclk);
        end
    endtask

    initial begin
        repeat (10) @(posedge i_mclk);
        i_reset <= 1'h0;
        xf(0, 12'h21c, 0);
        chk("pc_rst", rd, 32'h30);
        xf(0, 12'h100, 0);
        chk("unmapped", rsp, 32'h2);
        xf(1, 12'h21c, 32'h0);
        xf(0, 12'h21c, 0);
        chk("flag_clr", rd, 32'h0);
        xf(1, 12'h21c, 32'h1);
        repeat (3) @(posedge i_mclk);
        chk("lt_halt", o_cpu_halt, 32'h1);
        chk("lt_osc", o_osc_stop, 32'h0);
        i_irq_pending <= 1'h1;
        run();
        i_irq_pending <= 1'h0;
        xf(0, 12'h21c, 0);
        chk("lt_clr", rd, 32'h0);
        $display("test light_sleep done");
        // Both sleep bits at once, both start-up counts
        for (int c = 0; c < 2; c++) begin
            i_crystal_osc_cfg <= c[0];
            xf(1, 12'h21c, 32'h3);
            repeat (4) @(posedge i_mclk);
            chk("dp_osc", o_osc_stop, 32'h1);
            i_wake_irq <= 1'h1;
            run();
            i_wake_irq <= 1'h0;
            n -= c ? `OSC_WAIT_CRYSTAL : `OSC_WAIT_RC;
            chk("dp_wait", n >= 0 && n <= 10, 32'h1);
            xf(0, 12'h21c, 0);
            chk("dp_clr", rd, 32'h0);
        end
        $display("test deep_sleep done");
        xf(1, 12'h288, 32'h20);
        xf(1, 12'h308, 32'h0);
        i_brownout_irq_enable <= 1'h1;
        xf(1, 12'h21c, 32'h2);
        i_brownout_low_raw <= 1'h1;
        run();
        chk("bo_irq", o_brownout_irq, 32'h1);
        chk("bo_norst", o_sys_reset, 32'h0);
        chk("irq_msk", o_irq, 32'h0);
        xf(1, 12'h308, 32'h3);
        repeat (2) @(posedge i_mclk);
        chk("irq", o_irq, 32'h1);
        xf(0, 12'h21c, 0);
        chk("bo_flag", rd, 32'h20);
        i_brownout_low_raw <= 1'h0;
        repeat (4) @(posedge i_mclk);
        xf(1, 12'h304, 32'h3);
        xf(0, 12'h304, 0);
        chk("stat_clr", rd, 32'h0);
        // Disabled detector must stay silent
        xf(1, 12'h288, 32'h60);
        i_brownout_low_raw <= 1'h1;
        repeat (8) @(posedge i_mclk);
        chk("dis_irq", o_brownout_irq, 32'h0);
        chk("dis_rst", o_sys_reset, 32'h0);
        i_brownout_low_raw <= 1'h0;
        xf(1, 12'h288, 32'h0);
        i_brownout_high_raw <= 1'h1;
        repeat (8) @(posedge i_mclk);
        chk("lo_trip", o_sys_reset, 32'h0);
        i_brownout_level_select <= 1'h0;
        repeat (8) @(posedge i_mclk);
        chk("hi_trip", o_sys_reset, 32'h1);
        i_brownout_high_raw <= 1'h0;
        run();
        xf(0, 12'h21c, 0);
        chk("bo_pc", rd, 32'h20);
        $display("test brownout done");
        for (int s = 0; s < 2; s++) begin
            i_por_detect <= !s;
            i_wdt_reset_async <= s[0];
            repeat (8) @(posedge i_mclk);
            chk("src_rst", o_sys_reset, 32'h1);
            i_por_detect <= 1'h0;
            i_wdt_reset_async <= 1'h0;
            run();
            xf(0, 12'h21c, 0);
            chk("src_pc", rd, s ? 32'h0 : 32'h30);
        end
        $display("test reset_sources done");
        wrap_up();
    end
endmodule
`default_nettype wire
